// *** fwc_pkg.sv ***
// Package of constants and types for the nonvolatile array access wait control
//==========================================================================
// Operation
// [RQ1] Array is accessed at most once per 125 ns, reads and writes alike. Reset clears gap_reg, so an access can follow sooner.
// [RQ2] Bus clock may run at 16 or 24 MHz, above array rate.
// [RQ3] Above 8 MHz the requesting master is stalled with wait states.
// [RQ4] Wait count chosen automatically or programmed by software.
// [RQ5] A word or byte write completes within one 125 ns access.
// [RQ6] Writes take effect directly with no erase step.
// [RQ7] Array is unsegmented; every bit individually writable like static RAM.
// [RQ8] A plain bus write suffices; no unlock or setup step.
// [RQ9] Cache hits run without wait states; only array accesses stall.
// [RQ10] Automatic count is the least extra cycles reaching 125 ns.
//==========================================================================
package fwc_pkg;
    localparam int ADDR_W = 10;
    localparam int DATA_W = 16;
    localparam int WAIT_W = 4;
    localparam int DEPTH  = 1 << ADDR_W;
    // Timing
    localparam int ARRAY_NS    = 125;
    localparam int CLK_HZ      = 20000000;
    localparam int CLK_PS      = 1000000000 / (CLK_HZ / 1000);
    localparam int ARRAY_CYC   = (ARRAY_NS * 1000 + CLK_PS - 1) / CLK_PS;
    localparam logic [WAIT_W-1:0] AUTO_WAIT = WAIT_W'(ARRAY_CYC - 1);
    localparam logic [WAIT_W-1:0] WAIT_RST  = 4'h0;
    localparam logic [WAIT_W-1:0] GAP_RST   = 4'h0;
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_WAIT = 2'b01,
        ST_DONE = 2'b10
    } fwc_state_e;
endpackage : fwc_pkg

// *** fwc_array.sv ***
// Ferroelectric array model: bit-writable word memory with registered read
`timescale 1ns/1ps
module fwc_array
    import fwc_pkg::*;
(
    input  wire logic              clk_sys,   // System clock
    input  wire logic              en,        // Access strobe
    input  wire logic              wr,        // Write when high
    input  wire logic [ADDR_W-1:0] addr,      // Word address
    input  wire logic [DATA_W-1:0] wdata,     // Write data
    input  wire logic [DATA_W-1:0] bitMask,   // Bits to write
    output logic      [DATA_W-1:0] rdata      // Registered read data
);
    logic [DATA_W-1:0] mem [DEPTH];

    //==========================================================================
    // Storage
    // Each bit is merged in place; no erase precedes a write  see RQ6 see RQ7
    always_ff @(posedge clk_sys) begin
        if (en && wr) begin
            mem[addr] <= (mem[addr] & ~bitMask) | (wdata & bitMask);
        end
    end

    // Read port comes straight out of a register
    always_ff @(posedge clk_sys) begin
        if (en && !wr) begin
            rdata <= mem[addr];
        end
    end
endmodule : fwc_array

// *** fwc_access_ctrl.sv ***
// Access timing and wait-state control in front of the nonvolatile array
`timescale 1ns/1ps
module fwc_access_ctrl
    import fwc_pkg::*;
(
    input  wire logic              clk_sys,     // System clock, 20 MHz
    input  wire logic              reset_n,     // Asynchronous reset, active low
    input  wire logic              autoWait,    // 1 = automatic wait count
    input  wire logic [WAIT_W-1:0] manualWait,  // Software wait count
    input  wire logic              req,         // Master access request
    input  wire logic              wr,          // Write when high
    input  wire logic              cacheHit,    // Served by prefetch cache
    input  wire logic [ADDR_W-1:0] addr,        // Word address
    input  wire logic [DATA_W-1:0] wdata,       // Write data
    input  wire logic [1:0]        byteEn,      // Byte lanes to write
    output logic                   ready,       // Access complete, comb
    output logic      [DATA_W-1:0] rdata,       // Read data
    output logic                   busy         // Array access in progress
);
    // Sequencer state, wait and spacing counters
    fwc_state_e        state_reg, state_next;
    logic [WAIT_W-1:0] cnt_reg;
    logic [WAIT_W-1:0] gap_reg;
    logic [WAIT_W-1:0] waitSel;
    logic              arrEn;
    logic [DATA_W-1:0] bitMask;
    logic [DATA_W-1:0] arrData;

    //==========================================================================
    // Wait count selection
    // Manual count can exceed the minimum, never go below it, so a careless
    // setting cannot overrun the array  see RQ4 see RQ10
    // The minimum follows the system clock, so a faster clock gets more waits  see RQ2
    always_comb begin
        if (autoWait || manualWait < AUTO_WAIT) begin
            waitSel = AUTO_WAIT;
        end else begin
            waitSel = manualWait;
        end
    end

    // Array is started only on a cache miss, after the spacing gap has run out
    assign arrEn   = (state_reg == ST_IDLE) && req && !cacheHit && (gap_reg == 4'h0); // see RQ1
    assign bitMask = {{8{byteEn[1]}}, {8{byteEn[0]}}};  // see RQ7
    assign busy    = (state_reg != ST_IDLE);

    //==========================================================================
    // Sequencer
    // Idle, then the wait states, then one done cycle that raises ready
    always_comb begin
        state_next = state_reg;
        case (state_reg)
            ST_IDLE: begin
                if (arrEn) begin
                    state_next = (waitSel == 4'h0) ? ST_DONE : ST_WAIT;  // see RQ3
                end
            end
            ST_WAIT: begin
                if (cnt_reg == 4'h1) begin
                    state_next = ST_DONE;
                end
            end
            ST_DONE: state_next = ST_IDLE;  // see RQ5
            default: state_next = ST_IDLE;
        endcase
    end

    // State register
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            state_reg <= ST_IDLE;
        end else begin
            state_reg <= state_next;
        end
    end

    // Wait counter loaded at the start of each array access
    // Loaded as the access starts, so a later change of the setting cannot cut it short
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            cnt_reg <= WAIT_RST;
        end else if (arrEn) begin
            cnt_reg <= waitSel;
        end else if (state_reg == ST_WAIT) begin
            cnt_reg <= cnt_reg - 4'h1;
        end
    end

    // Spacing guard: no new access sooner than the array period, unless a reset clears it  see RQ1
    // Idle while accesses outlast the gap, but it still holds if the sequencer is shortened
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            gap_reg <= GAP_RST;
        end else if (arrEn) begin
            gap_reg <= WAIT_W'(ARRAY_CYC - 1);
        end else if (gap_reg != 4'h0) begin
            gap_reg <= gap_reg - 4'h1;
        end
    end

    // Hits answer at once; misses answer at the end of the access  see RQ9
    assign ready = (req && cacheHit && state_reg == ST_IDLE) || (state_reg == ST_DONE);

    // Read data taken from the array register on every clock, one cycle behind it
    // Follows the array register every cycle, so it stands until the next read
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            rdata <= '0;
        end else begin
            rdata <= arrData;
        end
    end

    //==========================================================================
    // Array, written directly with no unlock step  see RQ8 see RQ6
    fwc_array u_array (
        .clk_sys (clk_sys),
        .en      (arrEn),
        .wr      (wr),
        .addr    (addr),
        .wdata   (wdata),
        .bitMask (bitMask),
        .rdata   (arrData)
    );

    //==========================================================================
    // Checks
    // Helper counters saturate so they never wrap during long idle stretches
    // Cycles since the last array start
    int unsigned sinceAcc;
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            sinceAcc <= 100;
        end else if (arrEn) begin
            sinceAcc <= 0;
        end else if (sinceAcc < 100) begin
            sinceAcc <= sinceAcc + 1;
        end
    end

    // Cycles the running access has lasted, counted from its start
    int unsigned accLen;
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            accLen <= 0;
        end else if (arrEn) begin
            accLen <= 1;
        end else if (busy && accLen < 20) begin
            accLen <= accLen + 1;
        end
    end

    access_spacing_a: assert property ( // see RQ1
        @(posedge clk_sys) disable iff (!reset_n)
        arrEn |-> sinceAcc >= ARRAY_CYC - 1)
        else $error("array accessed faster than allowed");

    // Named steps of an access, shared by the properties below
    sequence missStart_s;
        arrEn;
    endsequence
    sequence missAsk_s;
        state_reg == ST_IDLE && req && !cacheHit && gap_reg == 4'h0;
    endsequence
    sequence hitServe_s;
        req && cacheHit && state_reg == ST_IDLE;
    endsequence

    write_done_a: assert property ( // see RQ5
        @(posedge clk_sys) disable iff (!reset_n)
        (missStart_s and (autoWait && wr)) |-> ##[1:3] (state_reg == ST_DONE))
        else $error("write not complete in one access time");

    hit_no_wait_a: assert property ( // see RQ9
        @(posedge clk_sys) disable iff (!reset_n)
        hitServe_s |-> ready ##1 !busy)
        else $error("cache hit stalled");

    wait_count_a: assert property ( // see RQ3
        @(posedge clk_sys) disable iff (!reset_n)
        (state_reg == ST_WAIT) |-> cnt_reg != 4'h0)
        else $error("wait counter ran out inside the wait state");

    miss_stall_a: assert property ( // see RQ3
        @(posedge clk_sys) disable iff (!reset_n)
        arrEn |-> !ready ##1 busy)
        else $error("miss not stalled");

    auto_count_a: assert property ( // see RQ10
        @(posedge clk_sys) disable iff (!reset_n)
        (arrEn && autoWait) |=> cnt_reg == AUTO_WAIT)
        else $error("automatic wait count wrong");

    auto_min_a: assert property ( // see RQ10
        @(posedge clk_sys) disable iff (!reset_n)
        (state_reg == ST_DONE && autoWait) |->
            accLen * CLK_PS >= ARRAY_NS * 1000 && (accLen - 1) * CLK_PS < ARRAY_NS * 1000)
        else $error("automatic wait count not the least that suffices");

    manual_count_a: assert property ( // see RQ4
        @(posedge clk_sys) disable iff (!reset_n)
        (arrEn && !autoWait && manualWait >= AUTO_WAIT) |=> cnt_reg == $past(manualWait))
        else $error("manual wait count not used");

    manual_len_a: assert property ( // see RQ4
        @(posedge clk_sys) disable iff (!reset_n)
        (state_reg == ST_DONE && !autoWait && manualWait >= AUTO_WAIT) |-> accLen == int'(manualWait) + 1)
        else $error("manual access length wrong");

    busy_end_a: assert property ( // see RQ2
        @(posedge clk_sys) disable iff (!reset_n)
        (state_reg == ST_DONE) |=> !busy)
        else $error("access did not end");

    no_unlock_a: assert property ( // see RQ8
        @(posedge clk_sys) disable iff (!reset_n)
        missAsk_s |-> arrEn ##[1:16] ready)
        else $error("plain request not served");

    read_data_a: assert property ( // see RQ7
        @(posedge clk_sys) disable iff (!reset_n)
        (state_reg == ST_DONE && !wr) |-> rdata == arrData)
        else $error("read data not ready at access end");
endmodule : fwc_access_ctrl

// *** fwc_master.sv ***
// Bus master model that issues one array access at a time
`timescale 1ns/1ps
module fwc_master
    import fwc_pkg::*;
(
    input  wire logic              clk_sys,  // System clock
    input  wire logic              ready,    // Access complete
    input  wire logic [DATA_W-1:0] rdata,    // Read data
    output logic                   req,      // Access request
    output logic                   wr,       // Write when high
    output logic                   cacheHit, // Served by cache
    output logic      [ADDR_W-1:0] addr,     // Word address
    output logic      [DATA_W-1:0] wdata,    // Write data
    output logic      [1:0]        byteEn    // Byte lanes
);
    int timeouts = 0;  // Accesses that never saw ready
    initial begin
        {req, wr, cacheHit, addr, wdata, byteEn} = '0;
    end
    // Hold until ready is seen high, then scramble so stale values never pass
    task automatic access(input logic w, input logic h, input logic [ADDR_W-1:0] a,
                          input logic [DATA_W-1:0] d, input logic [1:0] be,
                          output int lat, output logic [DATA_W-1:0] rd);
        lat = 0;
        @(negedge clk_sys);
        {req, wr, cacheHit, addr, wdata, byteEn} = {1'b1, w, h, a, d, be};
        do begin
            @(posedge clk_sys);
            lat++;
        end while (ready !== 1'b1 && lat < 40);
        if (ready !== 1'b1) timeouts++;
        rd = rdata;
        @(negedge clk_sys);
        {req, wr, cacheHit, addr, wdata, byteEn} = {1'b0, ~w, ~h, ~a, ~d, ~be};
    endtask : access
endmodule : fwc_master

// *** tb_fwc_access_ctrl.sv ***
// Self-checking bench for the array access wait control
`timescale 1ns/1ps
`define CHK(nm, exp, got) begin check_count++; if ((got) !== (exp)) begin n_mismatch++; \
    $display("unexpected %s expected %0h seen %0h", nm, exp, got); end end
module tb_fwc_access_ctrl
    import fwc_pkg::*;
;
    logic              clk_sys, reset_n, autoWait, req, wr, cacheHit, ready, busy;
    logic [WAIT_W-1:0] manualWait;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata, rdata, rd;
    logic [1:0]        byteEn;
    int                n_mismatch = 0, check_count = 0, cycles = 0, busyCycles = 0, lat;
    //==========================================================================
    // Design and master
    fwc_access_ctrl fwc_access_ctrl_i (.clk_sys(clk_sys), .reset_n(reset_n),
        .autoWait(autoWait), .manualWait(manualWait), .req(req), .wr(wr),
        .cacheHit(cacheHit), .addr(addr), .wdata(wdata), .byteEn(byteEn),
        .ready(ready), .rdata(rdata), .busy(busy));
    fwc_master fwc_master_i (.clk_sys(clk_sys), .ready(ready), .rdata(rdata), .req(req),
        .wr(wr), .cacheHit(cacheHit), .addr(addr), .wdata(wdata), .byteEn(byteEn));
    initial begin
        clk_sys = 1'b0;
        forever #25 clk_sys = ~clk_sys;
    end
    // Busy tally and hang guard; all tests fit well inside 2000 cycles
    always @(posedge clk_sys) begin
        cycles++;
        if (busy === 1'b1) busyCycles++;
        if (cycles > 2000) begin
            n_mismatch++;
            test_done();
        end
    end
    task test_done;
        if (n_mismatch == 0 && check_count > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask : test_done
    //==========================================================================
    // Scenarios
    // Plain writes at both end words, overwritten in place, then read back
    task t_write_read;
        `CHK("auto least", 1, int'((AUTO_WAIT + 1) * 50 >= 125 && AUTO_WAIT * 50 < 125))
        for (int i = 0; i < 2; i++) begin
            fwc_master_i.access(1'b1, 1'b0, ADDR_W'(i * 'h3ff), 16'h1234, 2'h3, lat, rd);
            `CHK("write wait", int'(AUTO_WAIT) + 2, lat)
            fwc_master_i.access(1'b1, 1'b0, ADDR_W'(i * 'h3ff), 16'hedcb, 2'h3, lat, rd);
            fwc_master_i.access(1'b0, 1'b0, ADDR_W'(i * 'h3ff), 16'h0000, 2'h0, lat, rd);
            `CHK("read wait", int'(AUTO_WAIT) + 2, lat)
            `CHK("overwrite", 16'hedcb, rd)
        end
    endtask : t_write_read
    // Single byte lanes change only their own bits
    task t_bytes;
        fwc_master_i.access(1'b1, 1'b0, 10'h005, 16'hffff, 2'h3, lat, rd);
        fwc_master_i.access(1'b1, 1'b0, 10'h005, 16'h0000, 2'h1, lat, rd);
        fwc_master_i.access(1'b0, 1'b0, 10'h005, 16'h0000, 2'h0, lat, rd);
        `CHK("low lane", 16'hff00, rd)
        fwc_master_i.access(1'b1, 1'b0, 10'h005, 16'ha5a5, 2'h2, lat, rd);
        fwc_master_i.access(1'b0, 1'b0, 10'h005, 16'h0000, 2'h0, lat, rd);
        `CHK("high lane", 16'ha500, rd)
    endtask : t_bytes
    // Software counts below the minimum are raised; larger ones stretch the access
    task automatic t_manual;
        logic [WAIT_W-1:0] m [3] = '{4'h0, 4'h5, 4'hf};
        for (int i = 0; i < 3; i++) begin
            @(negedge clk_sys);
            autoWait = 1'b0;
            manualWait = m[i];
            fwc_master_i.access(1'b0, 1'b0, 10'h005, 16'h0000, 2'h0, lat, rd);
            `CHK("manual wait", (m[i] > AUTO_WAIT ? int'(m[i]) : int'(AUTO_WAIT)) + 2, lat)
        end
        @(negedge clk_sys);
        autoWait = 1'b1;
    endtask : t_manual
    // Cache hits answer at once and never start an array access
    task t_hit;
        busyCycles = 0;
        fwc_master_i.access(1'b0, 1'b1, 10'h005, 16'h0000, 2'h0, lat, rd);
        `CHK("hit wait", 1, lat)
        `CHK("hit busy", 0, busyCycles)
        fwc_master_i.access(1'b0, 1'b0, 10'h005, 16'h0000, 2'h0, lat, rd);
        `CHK("miss busy", 1, int'(busyCycles > 0))
    endtask : t_hit
    // Reset in mid-access clears the controller but not the array contents
    task t_reset;
        fork
            fwc_master_i.access(1'b0, 1'b0, 10'h005, 16'h0000, 2'h0, lat, rd);
            begin
                repeat (2) @(negedge clk_sys);
                reset_n = 1'b0;
                @(negedge clk_sys);
                `CHK("reset busy", 1'b0, busy)
                `CHK("reset ready", 1'b0, ready)
                `CHK("reset rdata", 16'h0000, rdata)
                reset_n = 1'b1;
            end
        join
        `CHK("kept data", 16'ha500, rd)
    endtask : t_reset
    initial begin
        reset_n = 1'b0;
        autoWait = 1'b1;
        manualWait = 4'h0;
        repeat (12) @(negedge clk_sys);
        reset_n = 1'b1;
        t_write_read();
        t_bytes();
        t_manual();
        t_hit();
        t_reset();
        `CHK("master timeouts", 0, fwc_master_i.timeouts)
        test_done();
    end
endmodule : tb_fwc_access_ctrl
